// *** hdl/bpd_regs.svh ***
// bus pin direction control: reset values and synchroniser depth
`ifndef BPD_REGS_SVH
`define BPD_REGS_SVH
// flip-flops in each pin input synchroniser
`define BPD_SYNC_STAGES   2
// raw active-low pin level seen before any edge is captured
`define BPD_PIN_IDLE      1'h1
// output enables start released so the device drives nothing at reset
`define BPD_OE_RESET      1'h0
// active-low driven values start negated
`define BPD_NEG_RESET     1'h1
`endif

// *** hdl/bpd_pkg.sv ***
// bus pin direction control: shared types
package bpd_pkg;
  // current owner of the system bus
  typedef enum logic [1:0] {
    bpd_own_core,
    bpd_own_independent_dma_master,
    bpd_own_serial_dma_master,
    bpd_own_ext
  } bpd_owner_e;
  // raw active-low levels arriving on the two-way pins
  typedef struct packed {
    logic req_n;     // bus request pin level
    logic grant_n;   // bus grant pin level
    logic clr_n;     // bus clear pin level
    logic ack_n;     // transfer acknowledge pin level
    logic err_n;     // bus error pin level
    logic strobe_n;  // address strobe pin level
  } bpd_pin_in_s;
  // direction and drive of every pin group
  typedef struct packed {
    logic addr_oe;          // address, function code, strobes, r/w, indivisible
    logic data_oe;          // data pins driven
    logic data_capture;     // data pins sampled
    logic ack_oe;           // transfer acknowledge driven
    logic ack_out_n;        // transfer acknowledge level when driven
    logic grant_ack_oe;     // bus grant acknowledge driven low
    logic req_oe;           // bus request open-drain pulled low
    logic grant_oe;         // bus grant driven
    logic grant_out_n;      // bus grant level when driven
    logic clr_oe;           // bus clear open-drain pulled low
    logic error_oe;         // bus error open-drain pulled low
    logic internal_access;  // internal access output, active high
  } bpd_pins_s;
endpackage

// *** hdl/bpd_bus_pin_dir.sv ***
// bus pin direction control: owner and target decoding onto the shared bus pins
`timescale 1ns/10ps
`include "bpd_regs.svh"

module bpd_bus_pin_dir
  import bpd_pkg::*;
(
  input  wire logic        sys_clk,                    // 100 MHz system clock
  input  wire logic        rst,                        // synchronous reset, active high
  input  wire bpd_owner_e  owner,                      // current bus owner from arbiter
  input  wire logic        cycle_active,               // own master has a cycle running
  input  wire logic        target_internal,            // cycle addresses on-chip space
  input  wire logic        cycle_write,                // cycle is a write
  input  wire logic        core_disabled,              // core-disabled mode select
  input  wire logic        cs_ack_internal,            // chip-select makes acknowledge
  input  wire logic        cs_ack_assert,              // chip-select acknowledge now due
  input  wire logic        watchdog_expired,           // hardware watchdog timeout
  input  wire logic        addr_conflict,              // chip-select address conflict
  input  wire logic        write_protect_violation,    // chip-select write protect hit
  input  wire logic        internal_bus_clear_signal,  // on-chip bus clear for independent_dma_master
  input  wire logic        core_clear_req,             // core asks master to release bus
  input  wire logic        serial_dma_master_clear_req,             // serial dma asks for the bus
  input  wire logic        dma_bus_req,                // independent_dma_master or serial_dma_master wants the bus
  input  wire logic        arbiter_grant,              // on-chip arbiter grants external
  input  wire bpd_pin_in_s pin_in,                     // raw pin levels, asynchronous
  output bpd_pins_s        pins_r,                     // pin directions and drive
  output logic             independent_dma_master_bus_clear_r,           // bus clear seen by independent_dma_master
  output logic             dma_grant_r,                // grant seen by independent_dma_master and serial_dma_master
  output logic             ext_bus_request_r,          // external request to arbiter
  output logic             ext_ack_r,                  // acknowledge taken from pin
  output logic             bus_error_seen_r,           // bus error level on pin
  output logic             ext_access_accept_r         // external access to on-chip taken
);

  // two-stage synchronisers; stage one is read only by stage two
  bpd_pin_in_s sync1_r;   // first stage
  bpd_pin_in_s sync2_r;   // second stage, the only one logic reads
  bpd_pin_in_s sync1_nxt; // first stage next
  bpd_pin_in_s sync2_nxt; // second stage next

  // registered outputs next values
  bpd_pins_s   pins_nxt;                // pin direction next
  logic        independent_dma_master_bus_clear_nxt;      // independent_dma_master clear next
  logic        dma_grant_nxt;           // dma grant next
  logic        ext_bus_request_nxt;     // external request next
  logic        ext_ack_nxt;             // sampled acknowledge next
  logic        bus_error_seen_nxt;      // sampled bus error next
  logic        ext_access_accept_nxt;   // external access accept next

  // decode helpers
  logic        own_master;   // core, independent_dma_master or serial_dma_master holds the bus
  logic        dma_owner;    // independent_dma_master or serial_dma_master holds the bus
  logic        serial_dma_master_inside;  // serial_dma_master cycle to dual-port ram, off the bus
  logic        on_bus;       // the cycle actually appears on the pins
  logic        ext_cycle;    // external master strobe seen

  // a reset value for the whole sync struct
  function automatic bpd_pin_in_s idle_pins();
    bpd_pin_in_s p;
    p = '{default: `BPD_PIN_IDLE};
    return p;
  endfunction

  // synchroniser next values
  always_comb begin
    sync1_nxt = pin_in;
    sync2_nxt = sync1_r;
  end

  // synchroniser registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_r <= idle_pins();
      sync2_r <= idle_pins();
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // owner and target decode
  always_comb begin
    own_master  = (owner != bpd_own_ext);
    dma_owner   = (owner == bpd_own_independent_dma_master) || (owner == bpd_own_serial_dma_master);
    serial_dma_master_inside = (owner == bpd_own_serial_dma_master) && target_internal;
    on_bus      = own_master && !serial_dma_master_inside;
    // the strobe is synchronised, so its timing against sys_clk is free
    ext_cycle   = (owner == bpd_own_ext) && !sync2_r.strobe_n;
  end

  // pin direction and drive next values
  always_comb begin
    pins_nxt = '{default: `BPD_OE_RESET};
    pins_nxt.ack_out_n   = `BPD_NEG_RESET;
    pins_nxt.grant_out_n = `BPD_NEG_RESET;
    // address and control groups only while an own master is on the pins
    pins_nxt.addr_oe = on_bus;
    // drive data for on-chip reads and own writes, never off-bus serial_dma_master
    if (target_internal && !serial_dma_master_inside) begin
      pins_nxt.data_oe      = (!cycle_write) || own_master;
      pins_nxt.data_capture = cycle_write && !own_master;
    end else if (!target_internal) begin
      pins_nxt.data_oe      = own_master && cycle_write;
      pins_nxt.data_capture = !(own_master && cycle_write);
    end
    // acknowledge: on-chip space or chip-select made it, else leave to target
    if ((target_internal && !serial_dma_master_inside) || cs_ack_internal) begin
      pins_nxt.ack_oe    = 1'h1;
      pins_nxt.ack_out_n = !(cs_ack_assert || (target_internal && !own_master));
    end
    // internal access flag; serial_dma_master dual-port cycles never raise it
    pins_nxt.internal_access = target_internal && !serial_dma_master_inside &&
                               ((own_master && cycle_active) || ext_cycle);
    pins_nxt.grant_ack_oe = dma_owner;
    // error pull-down from on-chip sources only
    pins_nxt.error_oe = watchdog_expired || addr_conflict ||
                        write_protect_violation;
    if (core_disabled) begin
      // request becomes a dma open-drain output, grant becomes an input
      pins_nxt.req_oe = dma_bus_req;
      pins_nxt.clr_oe = serial_dma_master_clear_req;
    end else begin
      pins_nxt.grant_oe    = 1'h1;
      pins_nxt.grant_out_n = !arbiter_grant;
      pins_nxt.clr_oe      = core_clear_req || serial_dma_master_clear_req;
    end
  end

  // side-band next values for on-chip consumers
  always_comb begin
    // independent_dma_master clear from the pin only in core-disabled mode
    independent_dma_master_bus_clear_nxt  = core_disabled ? !sync2_r.clr_n
                                        : internal_bus_clear_signal;
    dma_grant_nxt       = core_disabled && !sync2_r.grant_n;
    ext_bus_request_nxt = !core_disabled && !sync2_r.req_n;
    // acknowledge from the pin matters only while the pin is an input;
    // the next enable is used so the refusal lines up with the drive cycle
    // limitation: just after release the synchroniser still holds our own level
    ext_ack_nxt         = !pins_nxt.ack_oe && !sync2_r.ack_n;
    // watched in every owner and target case
    bus_error_seen_nxt  = !sync2_r.err_n;
    ext_access_accept_nxt = ext_cycle && target_internal;
  end

  // output registers; every top output comes from here
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pins_r              <= '{default: `BPD_OE_RESET, ack_out_n: `BPD_NEG_RESET,
                               grant_out_n: `BPD_NEG_RESET};
      independent_dma_master_bus_clear_r    <= 1'h0;
      dma_grant_r         <= 1'h0;
      ext_bus_request_r   <= 1'h0;
      ext_ack_r           <= 1'h0;
      bus_error_seen_r    <= 1'h0;
      ext_access_accept_r <= 1'h0;
    end else begin
      pins_r              <= pins_nxt;
      independent_dma_master_bus_clear_r    <= independent_dma_master_bus_clear_nxt;
      dma_grant_r         <= dma_grant_nxt;
      ext_bus_request_r   <= ext_bus_request_nxt;
      ext_ack_r           <= ext_ack_nxt;
      bus_error_seen_r    <= bus_error_seen_nxt;
      ext_access_accept_r <= ext_access_accept_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // checks are written from the owner, target and mode inputs, except the serial dma quiet and
  // grant acknowledge checks, which reuse the serial_dma_master_inside and dma_owner helpers, the dma grant
  // and bus error monitor checks, which read sync2_r, and the acknowledge refusal check, which relates two outputs
  ext_addr_in_a: assert property (owner == bpd_own_ext |=> !pins_r.addr_oe)
    else $error("address pins driven under external master");
  core_addr_out_a: assert property (owner == bpd_own_core |=> pins_r.addr_oe)
    else $error("address pins released under core");
  serial_dma_master_quiet_a: assert property (serial_dma_master_inside |=>
    !pins_r.addr_oe && !pins_r.internal_access)
    else $error("serial dma on-chip cycle reached the pins");
  iac_match_a: assert property ((owner == bpd_own_core || owner == bpd_own_independent_dma_master) &&
    target_internal && cycle_active |=> pins_r.internal_access)
    else $error("internal access flag not raised for on-chip cycle");
  iac_off_a: assert property (!target_internal |=> !pins_r.internal_access)
    else $error("internal access flag raised for external target");
  grant_dir_a: assert property (!core_disabled |=>
    pins_r.grant_oe && !pins_r.req_oe)
    else $error("grant and request direction wrong in normal mode");
  dma_grant_a: assert property (core_disabled && !sync2_r.grant_n |=> dma_grant_r)
    else $error("dma grant not taken from pin");
  clr_src_a: assert property (!core_disabled |=>
    independent_dma_master_bus_clear_r == $past(internal_bus_clear_signal))
    else $error("independent_dma_master clear not from internal signal");
  bus_grant_acknowledge_pin_dma_a: assert property (dma_owner |=> pins_r.grant_ack_oe)
    else $error("grant acknowledge not driven by dma owner");
  bus_error_pin_src_a: assert property ($rose(watchdog_expired) |=> pins_r.error_oe)
    else $error("bus error not pulled on watchdog");
  bus_error_pin_mon_a: assert property (!sync2_r.err_n |=> bus_error_seen_r)
    else $error("bus error pin not monitored");
  ack_in_a: assert property (!target_internal && !cs_ack_internal |=> !pins_r.ack_oe)
    else $error("acknowledge driven for external target");
  ack_refuse_a: assert property (pins_r.ack_oe |-> !ext_ack_r)
    else $error("acknowledge taken from pin while driving it");
  req_refuse_a: assert property (core_disabled |=> !ext_bus_request_r)
    else $error("external request taken in core-disabled mode");
  ext_wr_cap_a: assert property (owner == bpd_own_ext && cycle_write |=>
    pins_r.data_capture && !pins_r.data_oe)
    else $error("external write not captured");

endmodule

// *** tb/bpd_ext_model.sv ***
// far-side model: external master, targets and pull-ups on the shared bus pins
`timescale 1ns/10ps
module bpd_ext_model
  import bpd_pkg::*;
(
  input  wire bpd_pins_s   pins,     // device direction and drive
  input  wire bpd_pin_in_s ext_drv,  // far-side active-low drive, 1 = released
  output bpd_pin_in_s      pin_in    // resolved wire levels seen by the device
);
  // open-drain lines idle high through pull-ups; either party may pull low
  // push-pull lines follow whoever enables; a released strobe idles high
  assign pin_in = '{
    ~pins.req_oe & ext_drv.req_n,
    pins.grant_oe ? pins.grant_out_n : ext_drv.grant_n,
    ~pins.clr_oe & ext_drv.clr_n,
    pins.ack_oe ? pins.ack_out_n : ext_drv.ack_n,
    ~pins.error_oe & ext_drv.err_n,
    pins.addr_oe ? 1'h1 : ext_drv.strobe_n
  };
endmodule

// *** tb/bpd_bus_pin_dir_tb.sv ***
// testbench: pin directions for every owner, target and mode
`timescale 1ns/10ps
module bpd_bus_pin_dir_tb;
  import bpd_pkg::*;
  logic        sys_clk, rst, cyc, ti, wr, cdis, ack_int, ack_now, wdog, confl, wprot;
  logic        int_clr, clr_core, clr_serial_dma_master, dma_req, arb_gnt;
  logic        independent_dma_master_clr, dma_gnt, ext_req, ext_ack, err_seen, acc_ok;
  bpd_owner_e  owner;    // bus owner under test
  bpd_pin_in_s ext_drv;  // far-side drive intents
  bpd_pin_in_s pin_in;   // resolved pin levels
  bpd_pins_s   pins;     // device drive
  int          n_mismatch, compares, tick;

  bpd_bus_pin_dir i_dut (.sys_clk(sys_clk), .rst(rst), .owner(owner), .cycle_active(cyc),
    .target_internal(ti), .cycle_write(wr), .core_disabled(cdis), .cs_ack_internal(ack_int),
    .cs_ack_assert(ack_now), .watchdog_expired(wdog), .addr_conflict(confl),
    .write_protect_violation(wprot), .internal_bus_clear_signal(int_clr),
    .core_clear_req(clr_core), .serial_dma_master_clear_req(clr_serial_dma_master), .dma_bus_req(dma_req),
    .arbiter_grant(arb_gnt), .pin_in(pin_in), .pins_r(pins), .independent_dma_master_bus_clear_r(independent_dma_master_clr),
    .dma_grant_r(dma_gnt), .ext_bus_request_r(ext_req), .ext_ack_r(ext_ack),
    .bus_error_seen_r(err_seen), .ext_access_accept_r(acc_ok));
  bpd_ext_model i_ext (.pins(pins), .ext_drv(ext_drv), .pin_in(pin_in));

  // free-running clock; the counter cuts a hang short
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    tick++;
    if (tick == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // every output is a level: four cycles cover the 3-cycle pin path
  task automatic go(input bpd_owner_e o, input logic t, input logic w);
    owner = o;
    ti = t;
    wr = w;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic idle();
    {cyc, ti, wr, cdis, ack_int, ack_now, wdog, confl, wprot} = 9'h100;
    {int_clr, clr_core, clr_serial_dma_master, dma_req, arb_gnt} = 5'h00;
    ext_drv = '1;
  endtask

  task automatic t_owner();
    bpd_owner_e o;
    idle();
    for (int i = 0; i < 4; i++) begin
      o = bpd_owner_e'(i);
      go(o, 1'h0, 1'h0);
      chk("addr_oe", pins.addr_oe, o != bpd_own_ext);
      chk("grant_ack_oe", pins.grant_ack_oe, o inside {bpd_own_independent_dma_master, bpd_own_serial_dma_master});
      chk("capture", pins.data_capture, 1'h1);
    end
  endtask
  task automatic t_space();
    idle();
    go(bpd_own_core, 1'h1, 1'h1);
    chk("int_access", pins.internal_access, 1'h1);
    chk("data_oe", pins.data_oe, 1'h1);
    chk("ack_oe", pins.ack_oe, 1'h1);
    go(bpd_own_serial_dma_master, 1'h1, 1'h0);
    chk("int_access", pins.internal_access, 1'h0);
    go(bpd_own_independent_dma_master, 1'h1, 1'h0);
    chk("int_access", pins.internal_access, 1'h1);
    cyc = 1'h0;
    go(bpd_own_independent_dma_master, 1'h1, 1'h0);
    chk("idle_access", pins.internal_access, 1'h0);
    go(bpd_own_serial_dma_master, 1'h0, 1'h1);
    chk("ext_wr", {pins.data_oe, pins.data_capture, pins.addr_oe}, 3'h5);
  endtask
  task automatic t_ext();
    idle();
    ext_drv.strobe_n = 1'h0;
    go(bpd_own_ext, 1'h1, 1'h0);
    chk("accept", acc_ok, 1'h1);
    chk("int_access", pins.internal_access, 1'h1);
    chk("ack_low", {pins.ack_oe, pins.ack_out_n}, 2'h2);
    chk("data_oe", pins.data_oe, 1'h1);
    go(bpd_own_ext, 1'h1, 1'h1);
    chk("wr_capture", {pins.data_oe, pins.data_capture}, 2'h1);
  endtask
  task automatic t_ack_err();
    idle();
    ext_drv.ack_n = 1'h0;
    go(bpd_own_core, 1'h0, 1'h0);
    chk("ext_ack", {pins.ack_oe, ext_ack}, 2'h1);
    ack_int = 1'h1;
    ack_now = 1'h1;
    go(bpd_own_core, 1'h0, 1'h0);
    chk("int_ack", {pins.ack_oe, pins.ack_out_n, ext_ack}, 3'h4);
    for (int i = 0; i < 3; i++) begin
      {wdog, confl, wprot} = 3'h1 << i;
      go(bpd_own_independent_dma_master, 1'h0, 1'h0);
      chk("error_oe", pins.error_oe, 1'h1);
      {wdog, confl, wprot} = 3'h0;
      go(bpd_own_ext, 1'h0, 1'h0);
      chk("error_off", pins.error_oe, 1'h0);
    end
    ext_drv.err_n = 1'h0;
    go(bpd_own_ext, 1'h1, 1'h0);
    chk("err_seen", err_seen, 1'h1);
  endtask
  task automatic t_mode();
    idle();
    {int_clr, arb_gnt} = 2'h3;
    ext_drv.req_n = 1'h0;
    go(bpd_own_independent_dma_master, 1'h0, 1'h0);
    chk("normal", {independent_dma_master_clr, dma_gnt, ext_req, pins.grant_oe, pins.grant_out_n}, 5'h16);
    {int_clr, clr_core} = 2'h1;
    go(bpd_own_independent_dma_master, 1'h0, 1'h0);
    chk("core_clr", {pins.clr_oe, independent_dma_master_clr}, 2'h2);
    {clr_core, cdis, dma_req, clr_serial_dma_master} = 4'h7;
    ext_drv.clr_n = 1'h0;
    ext_drv.grant_n = 1'h0;
    go(bpd_own_independent_dma_master, 1'h0, 1'h0);
    chk("independent_dma_master_clr", independent_dma_master_clr, 1'h1);
    chk("dma_pins", {pins.req_oe, dma_gnt, ext_req}, 3'h6);
    chk("reversed", {pins.grant_oe, pins.clr_oe}, 2'h1);
  endtask

  task automatic end_sim();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // reset held eight cycles, then each scenario in turn
  initial begin
    idle();
    owner = bpd_own_core;
    rst = 1'h1;
    repeat (8) @(negedge sys_clk);
    chk("reset_pins", pins, 12'h088);
    rst = 1'h0;
    t_owner();
    t_space();
    t_ext();
    t_ack_err();
    t_mode();
    end_sim();
  end
endmodule
